// [design/tpp_pkg.sv]
package tpp_pkg;
  // Avalon byte offsets
  localparam logic [3:0] REG_INDEX = 4'h0;
  localparam logic [3:0] REG_DATA  = 4'h4;
  localparam logic [3:0] REG_CTRL  = 4'h8;

  // Indexed controller registers
  localparam logic [3:0] IX_H_TOTAL   = 4'h0;
  localparam logic [3:0] IX_H_DISP    = 4'h1;
  localparam logic [3:0] IX_HS_POS    = 4'h2;
  localparam logic [3:0] IX_SYNC_WID  = 4'h3;
  localparam logic [3:0] IX_V_TOTAL   = 4'h4;
  localparam logic [3:0] IX_V_DISP    = 4'h5;
  localparam logic [3:0] IX_VS_POS    = 4'h6;
  localparam logic [3:0] IX_MAX_SCAN  = 4'h7;
  localparam logic [3:0] IX_CUR_START = 4'h8;
  localparam logic [3:0] IX_CUR_END   = 4'h9;
  localparam logic [3:0] IX_START_HI  = 4'hA;
  localparam logic [3:0] IX_START_LO  = 4'hB;
  localparam logic [3:0] IX_CURS_HI   = 4'hC;
  localparam logic [3:0] IX_CURS_LO   = 4'hD;
  localparam logic [3:0] IX_PEN_HI    = 4'hE;
  localparam logic [3:0] IX_PEN_LO    = 4'hF;

  // Values after reset
  localparam logic [7:0] RST_H_TOTAL   = 8'h3F;
  localparam logic [7:0] RST_H_DISP    = 8'h28;
  localparam logic [7:0] RST_HS_POS    = 8'h30;
  localparam logic [7:0] RST_SYNC_WID  = 8'h24;
  localparam logic [7:0] RST_V_TOTAL   = 8'h1F;
  localparam logic [7:0] RST_V_DISP    = 8'h19;
  localparam logic [7:0] RST_VS_POS    = 8'h1B;
  localparam logic [7:0] RST_MAX_SCAN  = 8'h0D;
  localparam logic [7:0] RST_CUR_START = 8'h0B;
  localparam logic [7:0] RST_CUR_END   = 8'h0C;
  localparam logic [2:0] RST_CTRL      = 3'h0;

  // Control register bits
  localparam int CTRL_HOLD   = 0;
  localparam int CTRL_MIRROR = 1;
  localparam int CTRL_FREEZE = 2;

  // Dot positions within one character time (eight dots)
  localparam logic [2:0] LATCH_DOT  = 3'h3;
  localparam logic [2:0] ADV_DOT    = 3'h7;
  localparam logic [2:0] PHASE2_DOT = 3'h4;
  localparam int         CHAR_HIGH_BIT = 2;

  // Flash dividers on vertical sync
  localparam int CURSOR_FLASH_BIT = 3;
  localparam int CHAR_FLASH_BIT   = 4;

  // Attribute fields
  localparam int ATTR_INTENS = 3;
  localparam int ATTR_BLINK  = 7;
endpackage

// [design/tpp_pixel_pipe.sv]
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
// How it works
// - Memory address counter starts at zero or start address, steps once per character.
// - Twelve-bit cell address and four-bit glyph row address are produced.
// - At line end glyph row increments and address returns to line start.
// - Character and attribute memories share the cell address only.
// - Character code latched on character clock; code plus row address the font.
// - Font byte loads while load select high, then shifts one bit per dot.
// - Pixel blocked by active-low gate, then XORed with invert.
// - Pixel registered per dot; strap picks true or complemented video pin.
// - Attribute decoded to active-low gate and invert; intensity passes raw.
// - Gate, invert, intensity delayed two character clocks; intensity registered per dot.
// - Delayed blink bit gates the intensity path into the output register.
// - Syncs follow the same delay and output registers as video.
// - Vertical sync divided into cursor and character flash clocks.
// - Controller hold clears scan counters and address (flash divider keeps its count), drives outputs low, keeps programmed registers.
// - Rising pen strobe captures current address into pen register.
// - Display window output high while display memory is fetched.
// - Cursor output asserts at programmed cursor address.
// - Write stores to addressed register, except the read-only pen pair; read returns it.
// - Select 0 reaches index register, select 1 the indexed register.
// - Host cycles ignored unless device select is low.
// - Syncs derived from counts with programmed position and width.
// - Shift register holds, shifts right or shifts left by mode selects.
// - Both selects high load; clear needs upper select low.
// - Character clock is dot clock over eight.
// - Controller owns memory address while character clock low, host when high.
module tpp_pixel_pipe (
  input  wire logic        clk,                  // 25 MHz dot clock
  input  wire logic        nrst,                 // Async reset, active low
  input  wire logic [3:0]  avs_address,          // Byte address
  input  wire logic        avs_read,             // Read request
  input  wire logic        avs_write,            // Write request
  input  wire logic [31:0] avs_writedata,        // Write data
  output logic      [31:0] avs_readdata,         // Read data
  output logic             avs_waitrequest,      // Stall
  input  wire logic        dev_sel_n,            // Device select, active low
  input  wire logic [11:0] host_addr,            // Host memory address
  output logic      [11:0] mem_addr,             // Muxed memory address
  output logic      [11:0] char_cell_addr,       // Controller cell address
  output logic      [3:0]  glyph_row_addr,       // Scan line in glyph
  input  wire logic [7:0]  char_data,            // Character memory data
  input  wire logic [7:0]  attr_data,            // Attribute memory data
  output logic      [11:0] font_addr,            // Font ROM address
  input  wire logic [7:0]  font_data,            // Font ROM pixel byte
  output logic             char_clk,             // Character clock
  output logic             display_window_active, // Fetching display memory
  output logic             cursor_active,        // Cursor at this cell
  input  wire logic        pen_strobe,           // Light pen strobe
  input  wire logic        video_polarity_strap, // Video pin polarity
  output logic             video_out,            // Video pin
  output logic             intensity_out,        // Intensity pin
  output logic             hsync_out,            // Horizontal sync pin
  output logic             vsync_out             // Vertical sync pin
);

  // Pipeline stage bits: gate_n, invert_n, intens, cursor, window, hsync, vsync
  typedef struct packed {
    logic gate_n;
    logic invert_n;
    logic intens;
    logic cur;
    logic win;
    logic hs;
    logic vs;
  } tpp_stage_t;

  typedef struct packed {
    logic [2:0]       dot_cnt;
    logic             ack;
    logic [7:0]       rdata;
    logic [3:0]       index;
    logic [15:0][7:0] regs;
    logic [2:0]       ctrl;
    logic [7:0]       h_cnt;
    logic [3:0]       scan;
    logic [6:0]       row;
    logic             vs_on;
    logic [3:0]       vs_cnt;
    logic [11:0]      ma;
    logic [11:0]      line_start;
    logic             pen_prev;
    logic             vs_prev;
    logic [4:0]       flash_cnt;
    logic [7:0]       code;
    tpp_stage_t       d1;
    tpp_stage_t       d2;
    logic             blink_d;
    logic [7:0]       sr;
    logic             video_q;
    logic             intens_q;
    logic             hs_q;
    logic             vs_q;
    logic             strap_done;
    logic             strap_val;
  } tpp_state_t;

  tpp_state_t s;
  tpp_state_t next_s;
  logic       rst_meta;
  logic       rst_n;

  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  logic        hold;
  logic        latch_en;
  logic        adv_en;
  logic        line_end;
  logic        frame_end;
  logic [7:0]  h_off;
  logic        hs_live;
  logic        win_live;
  logic        cur_live;
  logic        cursor_flash_clock;
  logic        char_flash_clock;
  logic [11:0] start_addr;
  logic [11:0] cursor_addr;
  logic [3:0]  max_scan;
  logic        mode_sel_lo;
  logic        mode_sel_hi;
  logic        right_serial_out;
  logic        left_serial_out;
  logic        right_fill_in;
  logic        left_fill_in;
  logic        sr_clear_n;
  logic        pix_raw;
  logic        pix;
  logic        intens_gated;
  logic        req;
  logic        sel_ok;
  logic [7:0]  bus_val;

  assign hold      = s.ctrl[tpp_pkg::CTRL_HOLD];
  assign char_clk  = s.dot_cnt[tpp_pkg::CHAR_HIGH_BIT];
  assign latch_en  = s.dot_cnt == tpp_pkg::LATCH_DOT;
  assign adv_en    = s.dot_cnt == tpp_pkg::ADV_DOT;
  assign line_end  = adv_en && s.h_cnt == s.regs[tpp_pkg::IX_H_TOTAL];
  assign max_scan  = s.regs[tpp_pkg::IX_MAX_SCAN][3:0];
  assign frame_end = line_end && s.scan == max_scan
                     && s.row == s.regs[tpp_pkg::IX_V_TOTAL][6:0];
  assign start_addr  = {s.regs[tpp_pkg::IX_START_HI][3:0], s.regs[tpp_pkg::IX_START_LO]};
  assign cursor_addr = {s.regs[tpp_pkg::IX_CURS_HI][3:0], s.regs[tpp_pkg::IX_CURS_LO]};

  // Controller outputs, low while held except the flash clocks, which keep their value
  assign h_off    = s.h_cnt - s.regs[tpp_pkg::IX_HS_POS];
  assign hs_live  = !hold && s.h_cnt >= s.regs[tpp_pkg::IX_HS_POS]
                    && h_off < {4'h0, s.regs[tpp_pkg::IX_SYNC_WID][3:0]};
  assign win_live = !hold && s.h_cnt < s.regs[tpp_pkg::IX_H_DISP]
                    && s.row < s.regs[tpp_pkg::IX_V_DISP][6:0];
  assign cursor_flash_clock = s.flash_cnt[tpp_pkg::CURSOR_FLASH_BIT];
  assign char_flash_clock   = s.flash_cnt[tpp_pkg::CHAR_FLASH_BIT];
  assign cur_live = win_live && s.ma == cursor_addr && cursor_flash_clock
                    && s.scan >= s.regs[tpp_pkg::IX_CUR_START][3:0]
                    && s.scan <= s.regs[tpp_pkg::IX_CUR_END][3:0];
  assign display_window_active = win_live;
  assign cursor_active         = cur_live;
  assign char_cell_addr        = s.ma;
  assign glyph_row_addr        = s.scan;
  // Cell address reaches memory in the low half of the character clock; host owns the high half
  assign mem_addr  = char_clk ? host_addr : s.ma;
  assign font_addr = {s.code, s.scan};

  // Shift register mode selects; mirror shifts the other way
  assign mode_sel_hi      = adv_en || s.ctrl[tpp_pkg::CTRL_MIRROR];
  assign mode_sel_lo      = !s.ctrl[tpp_pkg::CTRL_FREEZE]
                            && (adv_en || !s.ctrl[tpp_pkg::CTRL_MIRROR]);
  assign sr_clear_n       = !(hold && !mode_sel_hi);
  assign right_serial_out = s.sr[7];
  assign left_serial_out  = s.sr[0];
  assign right_fill_in    = 1'b0;
  assign left_fill_in     = 1'b0;

  assign pix_raw = s.ctrl[tpp_pkg::CTRL_MIRROR] ? left_serial_out : right_serial_out;
  // Gate first, then invert; outside the window stays background
  assign pix = s.d2.win && (((pix_raw && s.d2.gate_n) ^ !s.d2.invert_n)
                            || s.d2.cur);
  assign intens_gated = s.d2.win && s.d2.intens
                        && !(s.blink_d && char_flash_clock);

  // Bus
  assign req     = avs_read || avs_write;
  assign sel_ok  = !dev_sel_n;
  assign avs_waitrequest = req && !s.ack;
  assign avs_readdata    = {24'h0000_00, s.rdata};

  always_comb begin
    bus_val = 8'h00;
    if (sel_ok) begin
      unique case (avs_address)
        tpp_pkg::REG_INDEX: bus_val = {4'h0, s.index};
        tpp_pkg::REG_DATA:  bus_val = s.regs[s.index];
        tpp_pkg::REG_CTRL:  bus_val = {char_flash_clock, cursor_flash_clock, s.vs_on,
                                       hs_live, win_live, s.ctrl};
        default:            bus_val = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_s = s;
    next_s.dot_cnt = s.dot_cnt + 3'h1;

    // Bus: one wait state, write lands when waitrequest is low
    next_s.ack = req && !s.ack;
    if (req && !s.ack) begin
      next_s.rdata = bus_val;
    end
    if (avs_write && s.ack && sel_ok) begin
      unique case (avs_address)
        tpp_pkg::REG_INDEX: next_s.index = avs_writedata[3:0];
        tpp_pkg::REG_DATA: begin
          // Pen registers are read only
          if (s.index != tpp_pkg::IX_PEN_HI && s.index != tpp_pkg::IX_PEN_LO) begin
            next_s.regs[s.index] = avs_writedata[7:0];
          end
        end
        tpp_pkg::REG_CTRL:  next_s.ctrl = avs_writedata[2:0];
        default: begin
        end
      endcase
    end

    // Scan counters
    if (hold) begin
      next_s.h_cnt      = 8'h00;
      next_s.scan       = 4'h0;
      next_s.row        = 7'h00;
      next_s.vs_on      = 1'b0;
      next_s.vs_cnt     = 4'h0;
      next_s.ma         = 12'h000;
      next_s.line_start = 12'h000;
    end else if (adv_en) begin
      next_s.h_cnt = s.h_cnt + 8'h01;
      next_s.ma    = s.ma + 12'h001;
      if (line_end) begin
        next_s.h_cnt = 8'h00;
        if (frame_end) begin
          next_s.scan       = 4'h0;
          next_s.row        = 7'h00;
          next_s.line_start = start_addr;
          next_s.ma         = start_addr;
        end else if (s.scan == max_scan) begin
          next_s.scan       = 4'h0;
          next_s.row        = s.row + 7'h01;
          next_s.line_start = s.line_start + {4'h0, s.regs[tpp_pkg::IX_H_DISP]};
          next_s.ma         = s.line_start + {4'h0, s.regs[tpp_pkg::IX_H_DISP]};
        end else begin
          next_s.scan = s.scan + 4'h1;
          next_s.ma   = s.line_start;
        end
        // Vertical sync counted in scan lines
        if (next_s.scan == 4'h0 && next_s.row == s.regs[tpp_pkg::IX_VS_POS][6:0]) begin
          next_s.vs_on  = 1'b1;
          next_s.vs_cnt = 4'h0;
        end else if (s.vs_on) begin
          next_s.vs_cnt = s.vs_cnt + 4'h1;
          if (s.vs_cnt + 4'h1 == s.regs[tpp_pkg::IX_SYNC_WID][7:4]) begin
            next_s.vs_on = 1'b0;
          end
        end
      end
    end

    // Light pen; the pen registers have no other writer
    next_s.pen_prev = pen_strobe;
    if (pen_strobe && !s.pen_prev) begin
      next_s.regs[tpp_pkg::IX_PEN_HI] = {4'h0, s.ma[11:8]};
      next_s.regs[tpp_pkg::IX_PEN_LO] = s.ma[7:0];
    end

    // Flash divider on vertical sync rising edge
    next_s.vs_prev = s.vs_on;
    if (s.vs_on && !s.vs_prev) begin
      next_s.flash_cnt = s.flash_cnt + 5'h01;
    end

    // Character clock rising: latch code, decode attribute, advance delay
    if (latch_en) begin
      next_s.code        = char_data;
      next_s.d1.gate_n   = hold || attr_data[6:0] != 7'h00
                           && attr_data[6:0] != 7'h08;
      next_s.d1.invert_n = hold || attr_data[6:4] != 3'h7
                           || attr_data[2:0] != 3'h0;
      next_s.d1.intens   = !hold && attr_data[tpp_pkg::ATTR_INTENS];
      next_s.d1.cur      = cur_live;
      next_s.d1.win      = win_live;
      next_s.d1.hs       = hs_live;
      next_s.d1.vs       = !hold && s.vs_on;
      next_s.d2          = s.d1;
      next_s.blink_d     = attr_data[tpp_pkg::ATTR_BLINK];
    end

    // Shift register modes
    if (!sr_clear_n) begin
      next_s.sr = 8'h00;
    end else begin
      unique case ({mode_sel_hi, mode_sel_lo})
        2'b11: next_s.sr = font_data;
        2'b01: next_s.sr = {s.sr[6:0], right_fill_in};
        2'b10: next_s.sr = {left_fill_in, s.sr[7:1]};
        2'b00: next_s.sr = s.sr;
      endcase
    end

    // Dot-rate output registers
    next_s.video_q  = pix;
    next_s.intens_q = intens_gated;
    next_s.hs_q     = s.d2.hs;
    next_s.vs_q     = s.d2.vs;

    // Strap caught once after reset release
    if (!s.strap_done) begin
      next_s.strap_done = 1'b1;
      next_s.strap_val  = video_polarity_strap;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.regs[tpp_pkg::IX_H_TOTAL]   <= tpp_pkg::RST_H_TOTAL;
      s.regs[tpp_pkg::IX_H_DISP]    <= tpp_pkg::RST_H_DISP;
      s.regs[tpp_pkg::IX_HS_POS]    <= tpp_pkg::RST_HS_POS;
      s.regs[tpp_pkg::IX_SYNC_WID]  <= tpp_pkg::RST_SYNC_WID;
      s.regs[tpp_pkg::IX_V_TOTAL]   <= tpp_pkg::RST_V_TOTAL;
      s.regs[tpp_pkg::IX_V_DISP]    <= tpp_pkg::RST_V_DISP;
      s.regs[tpp_pkg::IX_VS_POS]    <= tpp_pkg::RST_VS_POS;
      s.regs[tpp_pkg::IX_MAX_SCAN]  <= tpp_pkg::RST_MAX_SCAN;
      s.regs[tpp_pkg::IX_CUR_START] <= tpp_pkg::RST_CUR_START;
      s.regs[tpp_pkg::IX_CUR_END]   <= tpp_pkg::RST_CUR_END;
      s.ctrl <= tpp_pkg::RST_CTRL;
    end else begin
      s <= next_s;
    end
  end

  // Complemented pin is a strap choice, not a register
  assign video_out     = s.strap_val ? !s.video_q : s.video_q;
  assign intensity_out = s.intens_q;
  assign hsync_out     = s.hs_q;
  assign vsync_out     = s.vs_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  addr_step_a: assert property (adv_en && !hold && !line_end |=> s.ma == $past(s.ma) + 12'h001)
    else $error("address did not step");
  line_wrap_a: assert property (line_end && !hold && s.scan != max_scan && !frame_end
                                |=> s.ma == $past(s.line_start) && s.scan == $past(s.scan) + 4'h1)
    else $error("line wrap wrong");
  code_latch_a: assert property (latch_en |=> font_addr[11:4] == $past(char_data))
    else $error("code not latched");
  sr_load_a: assert property (adv_en && sr_clear_n && !s.ctrl[tpp_pkg::CTRL_FREEZE]
                              |=> s.sr == $past(font_data))
    else $error("font byte not loaded");
  win_blank_a: assert property (!s.d2.win && !s.d2.cur |=> !s.video_q && !s.intens_q)
    else $error("pixel outside window");
  attr_delay_a: assert property (latch_en ##8 latch_en |=> s.d2.hs == $past(hs_live, 9))
    else $error("attribute delay wrong");
  pen_capture_a: assert property (pen_strobe && !s.pen_prev
                                  |=> {s.regs[tpp_pkg::IX_PEN_HI][3:0],
                                       s.regs[tpp_pkg::IX_PEN_LO]} == $past(s.ma))
    else $error("pen address not captured");
  hold_clear_a: assert property (hold |-> (!display_window_active && !cursor_active)
                                 ##1 (s.ma == 12'h000 && s.h_cnt == 8'h00))
    else $error("hold did not clear");
  mux_owner_a: assert property (!char_clk |-> mem_addr == char_cell_addr)
    else $error("mux not owned by controller");
  bus_ignore_a: assert property (avs_write && dev_sel_n |=> s.index == $past(s.index)
                                 && s.ctrl == $past(s.ctrl))
    else $error("deselected write took effect");
  char_div_a: assert property (latch_en |=> !latch_en [*7] ##1 latch_en)
    else $error("character clock not divide by eight");
endmodule

// [test/tpp_mono_monitor.sv]
`timescale 1ns/1ns
module tpp_mono_monitor (
  input wire logic clk,           // Dot clock
  input wire logic video_out,     // Video pin
  input wire logic intensity_out, // Intensity pin
  input wire logic hsync_out,     // Horizontal sync pin
  input wire logic vsync_out      // Vertical sync pin
);
  // A TTL monitor only measures; it never drives the card
  int   hs_per = 0;
  int   hs_wid = 0;
  int   vs_per = 0;
  int   hc     = 0;
  int   wc     = 0;
  int   vc     = 0;
  logic hs_d   = 1'b0;
  logic vs_d   = 1'b0;
  always @(posedge clk) begin
    hs_d <= hsync_out;
    vs_d <= vsync_out;
    hc   <= (hsync_out && !hs_d) ? 1 : hc + 1;
    vc   <= (vsync_out && !vs_d) ? 1 : vc + 1;
    wc   <= hsync_out ? wc + 1 : 0;
    if (hsync_out && !hs_d) hs_per <= hc;
    if (!hsync_out && hs_d) hs_wid <= wc;
    if (vsync_out && !vs_d) vs_per <= vc;
  end
endmodule

// [test/tb_text_mode_pixel_pipeline.sv]
`timescale 1ns/1ns
module tb_text_mode_pixel_pipeline;
  logic clk = 0, nrst = 0, avs_read = 0, avs_write = 0, dev_sel_n = 0, pen_strobe = 0;
  logic [3:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic [11:0] host_addr = 0, mem_addr, char_cell_addr, font_addr, prev_a;
  logic [7:0] char_data = 0, attr_data = 8'h07, font_data = 0;
  logic [3:0] glyph_row_addr, prev_r;
  logic avs_waitrequest, char_clk, display_window_active, cursor_active;
  logic video_out, intensity_out, hsync_out, vsync_out, prev_w;
  logic strap = 0;
  int err_total = 0, n_checks = 0, cyc = 0, lo_run = 0, lit_bg = 0, lit_fg = 0, hi, rises;
  int lit_in = 0;
  logic [3:0] ix [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
  logic [7:0] ex [10] = '{tpp_pkg::RST_H_TOTAL, tpp_pkg::RST_H_DISP, tpp_pkg::RST_HS_POS,
    tpp_pkg::RST_SYNC_WID, tpp_pkg::RST_V_TOTAL, tpp_pkg::RST_V_DISP, tpp_pkg::RST_VS_POS,
    tpp_pkg::RST_MAX_SCAN, tpp_pkg::RST_CUR_START, tpp_pkg::RST_CUR_END};
  tpp_pixel_pipe dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dev_sel_n(dev_sel_n), .host_addr(host_addr),
    .mem_addr(mem_addr), .char_cell_addr(char_cell_addr), .glyph_row_addr(glyph_row_addr),
    .char_data(char_data), .attr_data(attr_data), .font_addr(font_addr),
    .font_data(font_data), .char_clk(char_clk), .display_window_active(display_window_active),
    .cursor_active(cursor_active), .pen_strobe(pen_strobe), .video_polarity_strap(strap),
    .video_out(video_out), .intensity_out(intensity_out), .hsync_out(hsync_out),
    .vsync_out(vsync_out));
  tpp_mono_monitor mon (.clk(clk), .video_out(video_out), .intensity_out(intensity_out),
    .hsync_out(hsync_out), .vsync_out(vsync_out));
  initial begin
    forever #20 clk = ~clk;
  end
  // Memories answer one dot late, like slow static RAM
  always @(posedge clk) begin
    cyc <= cyc + 1;
    host_addr <= cyc[11:0];
    char_data <= mem_addr[7:0];
    font_data <= font_addr[7:0] ^ 8'h5A;
    if (cyc == 60000) begin
      err_total++;
      report_and_stop();
    end
  end
  // Retrace must stay dark once the two-character pipeline has drained
  always @(negedge clk) begin
    lo_run = display_window_active ? 0 : lo_run + 1;
    if (lo_run > 24 && video_out !== 1'b0) lit_bg++;
    if (video_out === 1'b1) lit_fg++;
    if (intensity_out === 1'b1) lit_in++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until the edge that sees waitrequest low; a hang ends at the bench timeout
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task automatic wreg(input logic [3:0] i, input logic [7:0] v);
    bus(1, tpp_pkg::REG_INDEX, {28'h0, i});
    bus(1, tpp_pkg::REG_DATA, {24'h0, v});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      bus(1, tpp_pkg::REG_INDEX, {28'h0, ix[i]});
      bus(0, tpp_pkg::REG_DATA, 0);
      chk(q, {24'h0, ex[i]});
    end
    wreg(tpp_pkg::IX_CURS_LO, 8'h5A);
    bus(0, tpp_pkg::REG_DATA, 0);
    chk(q, 32'h0000_005A);
    dev_sel_n <= 1;
    wreg(tpp_pkg::IX_CURS_LO, 8'h11);
    bus(0, tpp_pkg::REG_DATA, 0);
    chk(q, 32'h0000_0000);
    dev_sel_n <= 0;
    bus(0, tpp_pkg::REG_DATA, 0);
    chk(q, 32'h0000_005A);
    bus(0, 4'hC, 0);
    chk(q, 32'h0000_0000);
    wreg(tpp_pkg::IX_V_TOTAL, 8'h01);
    wreg(tpp_pkg::IX_V_DISP, 8'h01);
    wreg(tpp_pkg::IX_VS_POS, 8'h01);
    wreg(tpp_pkg::IX_MAX_SCAN, 8'h01);
    hi = 0;
    rises = 0;
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      if (char_clk === 1'b1) begin
        hi++;
        chk(mem_addr, host_addr);
      end
      if (i > 0 && char_clk === 1'b1 && prev_w === 1'b0) rises++;
      if (i == 62) chk(font_addr, {char_cell_addr[7:0], glyph_row_addr});
      prev_w = char_clk;
    end
    chk(hi, 32);
    chk(rises, 8);
    prev_w = 0;
    for (int i = 0; i < 200; i++) begin
      @(posedge char_clk);
      @(negedge clk);
      if (prev_w && display_window_active && glyph_row_addr === prev_r)
        chk(char_cell_addr, prev_a + 12'h001);
      prev_w = display_window_active;
      prev_a = char_cell_addr;
      prev_r = glyph_row_addr;
    end
    pen_strobe <= 1;
    repeat (6000) @(posedge clk);
    pen_strobe <= 0;
    chk(mon.hs_per, 32'(tpp_pkg::RST_H_TOTAL + 1) * 8);
    chk(mon.hs_wid, 32'(tpp_pkg::RST_SYNC_WID[3:0]) * 8);
    chk(mon.vs_per, 2 * 2 * 32'(tpp_pkg::RST_H_TOTAL + 1) * 8);
    chk(lit_bg, 0);
    chk(lit_fg > 0, 1);
    chk(lit_in, 0);
    // Gate off with intensity set: dark video, lit intensity
    attr_data <= 8'h08;
    repeat (40) @(posedge clk);
    hi = lit_fg;
    rises = lit_in;
    repeat (2100) @(posedge clk);
    chk(lit_fg, hi);
    chk(lit_in > rises, 1);
    bus(1, tpp_pkg::REG_CTRL, 32'h0000_0001);
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk({char_cell_addr, glyph_row_addr, hsync_out, display_window_active}, 0);
    bus(0, tpp_pkg::REG_CTRL, 0);
    chk(q & 32'h0000_0007, 32'h0000_0001);
    bus(1, tpp_pkg::REG_INDEX, {28'h0, tpp_pkg::IX_CURS_LO});
    bus(0, tpp_pkg::REG_DATA, 0);
    chk(q, 32'h0000_005A);
    bus(1, tpp_pkg::REG_CTRL, 0);
    repeat (100) @(posedge clk);
    nrst <= 0;
    @(negedge clk);
    chk({char_cell_addr, video_out, hsync_out}, 0);
    // Second release with the strap set: idle pixel shows complemented
    @(posedge clk);
    strap <= 1;
    nrst <= 1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(video_out, 1);
    report_and_stop();
  end
endmodule
